// file: rtl/sraf_pkg.sv
// Constants, register map and state types of the SPI register access front end.
package sraf_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam logic [14:0] A_CFG_A = 15'h0000;
  localparam logic [14:0] A_CFG_B = 15'h0001;
  localparam logic [14:0] A_CFG_C = 15'h0002;
  localparam logic [14:0] A_STAT = 15'h0003;
  localparam logic [14:0] A_MAKER_LO = 15'h000c;
  localparam logic [14:0] A_MAKER_HI = 15'h000d;
  localparam logic [14:0] A_R16_LO = 15'h0010;
  localparam logic [14:0] A_R16_HI = 15'h0011;
  localparam logic [14:0] A_R24_LO = 15'h0012;
  localparam logic [14:0] A_R24_MID = 15'h0013;
  localparam logic [14:0] A_R24_HI = 15'h0014;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int DIR_BIT = 5;
  localparam int SINGLE_BIT = 7;
  localparam int SHORT_BIT = 3;
  localparam int ENFORCE_BIT = 5;
  localparam int CCF_BIT = 4;
  localparam int SAF_BIT = 2;
  localparam logic DIR_RST = 1'b0;
  localparam logic SINGLE_RST = 1'b0;
  localparam logic SHORT_RST = 1'b1;
  localparam logic [15:0] R16_RST = 16'h0000;
  localparam logic [23:0] R24_RST = 24'h000000;

  // ----------------------------------------------------------------------
  // Frame counts
  // ----------------------------------------------------------------------
  localparam logic [4:0] INSTR_SHORT_BITS = 5'h08;
  localparam logic [4:0] INSTR_LONG_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [1:0] SIZE_SINGLE = 2'h0;
  localparam logic [1:0] SIZE_TWO = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRAF_IDLE = 3'b001,
    SRAF_INSTR = 3'b010,
    SRAF_DATA = 3'b100
  } sraf_phase_type;

  typedef struct packed {
    logic cs1;
    logic cs2;
    logic sck1;
    logic sck2;
    logic sck3;
    logic sdi1;
    logic sdi2;
  } sraf_sync_type;

  typedef struct packed {
    sraf_sync_type sync;
    sraf_phase_type phase;
    logic [4:0] bit_cnt;
    logic [15:0] ishift;
    logic [7:0] dsh;
    logic [7:0] tx;
    logic rd;
    logic [14:0] addr;
    logic sdo;
    logic sdo_oe;
    logic dir;
    logic single;
    logic short_ins;
    logic ccf;
    logic saf;
    logic [15:0] r16;
    logic [23:0] r24;
    logic [23:0] stage;
    logic [1:0] mb_cnt;
    logic mb_bad;
  } sraf_state_type;

endpackage

// file: rtl/sraf_frontend.sv
// SPI target front end giving a host byte access to the configuration register map.
// What this block does
// - Chip select falling starts a transaction; chip select high keeps the interface idle.
// - All instruction fields and data bytes travel most significant bit first.
// - Chip select rising mid-frame completes whole registers and drops partly addressed ones.
// - The instruction phase starts right after chip select falls, no idle bits.
// - Instruction is a direction bit then the address; low writes, high reads.
// - Address is 7 bits by default, 15 bits when the short-instruction bit is cleared.
// - Single-instruction mode needs an instruction per byte; streaming needs one per frame.
// - Data phase follows at once, carrying one register or a run of them.
// - A write commits right after the clock edge shifting the register's last bit.
// - Read data starts driving on the first clock edge of the data phase.
// - An incomplete write byte leaves the register alone and sets the clock-count fault.
// - Two- and three-byte registers sit at adjacent addresses and write as one unit.
// - The whole-register enforce bit is read-only and always reads one.
// - A multibyte register written byte per transaction stays unchanged, split fault set.
// - A multibyte write takes effect only after its 16th or 24th data clock edge.
// - Descending: first byte is the most significant, then next lower addresses.
// - Ascending: first byte is the least significant, then next higher addresses.
// - Byte-wise reads of multibyte registers return data and set the split fault.
// - The direction bit steps the address: zero decrements, one increments.
// - After reset the interface streams, stepping the address after each byte.
module sraf_frontend
  import sraf_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5a3c  // Arbitrary value.
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic [15:0] reg16_o,
  output logic [23:0] reg24_o,
  output logic clock_count_fault_o,
  output logic split_access_fault_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Unit decoders shared by the size and position decoders and by the commit.
  function automatic logic is_reg16(input logic [14:0] a);
    logic hit;
    hit = (a == A_R16_LO) || (a == A_R16_HI);
    return hit;
  endfunction

  function automatic logic is_reg24(input logic [14:0] a);
    logic hit;
    hit = (a >= A_R24_LO) && (a <= A_R24_HI);
    return hit;
  endfunction

  function automatic logic [1:0] mb_size(input logic [14:0] a);
    logic [1:0] sz;
    sz = SIZE_SINGLE;
    if (a == A_MAKER_LO || a == A_MAKER_HI || is_reg16(a)) begin
      sz = SIZE_TWO;
    end else if (is_reg24(a)) begin
      sz = SIZE_THREE;
    end
    return sz;
  endfunction

  function automatic logic [1:0] mb_pos(input logic [14:0] a);
    logic [14:0] d;
    d = 15'h0000;
    if (a == A_MAKER_HI || a == A_R16_HI) begin
      d = 15'h0001;
    end else if (is_reg24(a)) begin
      d = 15'(a - A_R24_LO);
    end
    return d[1:0];
  endfunction

  function automatic logic [7:0] read_byte(input sraf_state_type s, input logic [14:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      A_CFG_A: r[DIR_BIT] = s.dir;
      A_CFG_B: begin
        r[SINGLE_BIT] = s.single;
        r[SHORT_BIT] = s.short_ins;
      end
      A_CFG_C: r[ENFORCE_BIT] = 1'b1;
      A_STAT: begin
        r[CCF_BIT] = s.ccf;
        r[SAF_BIT] = s.saf;
      end
      A_MAKER_LO: r = MAKER_ID[7:0];
      A_MAKER_HI: r = MAKER_ID[15:8];
      A_R16_LO: r = s.r16[7:0];
      A_R16_HI: r = s.r16[15:8];
      A_R24_LO: r = s.r24[7:0];
      A_R24_MID: r = s.r24[15:8];
      A_R24_HI: r = s.r24[23:16];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  sraf_state_type s_r;
  sraf_state_type s_nxt;

  logic rise;
  logic fall;
  logic [15:0] ish;
  logic [4:0] bc;
  logic [4:0] ilen;
  logic [7:0] b;
  logic [1:0] sz;
  logic [1:0] k;
  logic [1:0] kstart;
  logic [1:0] cnt;
  logic [14:0] a_next;

  always_comb begin
    s_nxt = s_r;
    // --------------------------------------------------------------------
    // Synchronisers
    // --------------------------------------------------------------------
    // All three pins pass two stages, the clock a third for edge detection, so each data bit lines up with its clock edge.
    s_nxt.sync.cs1 = cs_b_i;
    s_nxt.sync.cs2 = s_r.sync.cs1;
    s_nxt.sync.sck1 = sclk_i;
    s_nxt.sync.sck2 = s_r.sync.sck1;
    s_nxt.sync.sck3 = s_r.sync.sck2;
    s_nxt.sync.sdi1 = sdi_i;
    s_nxt.sync.sdi2 = s_r.sync.sdi1;
    rise = s_r.sync.sck2 & ~s_r.sync.sck3;
    fall = ~s_r.sync.sck2 & s_r.sync.sck3;
    ish = {s_r.ishift[14:0], s_r.sync.sdi2};
    bc = 5'(s_r.bit_cnt + 5'h01);
    ilen = s_r.short_ins ? INSTR_SHORT_BITS : INSTR_LONG_BITS;
    b = {s_r.dsh[6:0], s_r.sync.sdi2};
    sz = mb_size(s_r.addr);
    k = mb_pos(s_r.addr);
    kstart = s_r.dir ? 2'h0 : 2'(sz - 2'h1);
    cnt = s_r.mb_cnt;
    a_next = s_r.dir ? 15'(s_r.addr + 15'h0001) : 15'(s_r.addr - 15'h0001);
    // --------------------------------------------------------------------
    // Frame end
    // --------------------------------------------------------------------
    if (s_r.sync.cs2) begin
      // Frame end: a write byte cut short never reaches a register.
      if (s_r.phase == SRAF_DATA && !s_r.rd && s_r.bit_cnt != 5'h00) begin
        s_nxt.ccf = 1'b1;
      end
      if (s_r.mb_cnt != 2'h0) begin
        s_nxt.saf = 1'b1;
      end
      s_nxt.phase = SRAF_IDLE;
      s_nxt.bit_cnt = 5'h00;
      s_nxt.ishift = 16'h0000;
      s_nxt.dsh = 8'h00;
      s_nxt.tx = 8'h00;
      s_nxt.mb_cnt = 2'h0;
      s_nxt.mb_bad = 1'b0;
      s_nxt.sdo = 1'b0;
      s_nxt.sdo_oe = 1'b0;
    end else begin
      if (s_r.phase == SRAF_IDLE) begin
        s_nxt.phase = SRAF_INSTR;
      end
      // ------------------------------------------------------------------
      // Instruction phase
      // ------------------------------------------------------------------
      if (s_r.phase != SRAF_DATA && rise) begin
        s_nxt.ishift = ish;
        s_nxt.bit_cnt = bc;
        if (bc == ilen) begin
          // Direction bit leads, address follows.
          if (s_r.short_ins) begin
            s_nxt.rd = ish[7];
            s_nxt.addr = {8'h00, ish[6:0]};
          end else begin
            s_nxt.rd = ish[15];
            s_nxt.addr = ish[14:0];
          end
          s_nxt.tx = read_byte(s_r, s_nxt.addr);
          s_nxt.phase = SRAF_DATA;
          s_nxt.bit_cnt = 5'h00;
          s_nxt.ishift = 16'h0000;
        end
      end
      // ------------------------------------------------------------------
      // Read shift-out
      // ------------------------------------------------------------------
      // Data moves on the falling edge so that it has settled when the host samples on the rise.
      if (s_r.phase == SRAF_DATA && fall && s_r.rd) begin
        s_nxt.sdo_oe = 1'b1;
        s_nxt.sdo = s_r.tx[7];
        s_nxt.tx = {s_r.tx[6:0], 1'b0};
      end
      // ------------------------------------------------------------------
      // Data bytes
      // ------------------------------------------------------------------
      if (s_r.phase == SRAF_DATA && rise) begin
        s_nxt.dsh = b;
        s_nxt.bit_cnt = bc;
        if (bc == BYTE_BITS) begin
          s_nxt.bit_cnt = 5'h00;
          if (sz == SIZE_SINGLE) begin
            if (!s_r.rd) begin
              unique case (s_r.addr)
                A_CFG_A: s_nxt.dir = b[DIR_BIT];
                A_CFG_B: begin
                  s_nxt.single = b[SINGLE_BIT];
                  s_nxt.short_ins = b[SHORT_BIT];
                end
                A_STAT: begin
                  // Clear by writing one; an abandoned multibyte unit can still set the split fault on this same byte.
                  s_nxt.ccf = s_r.ccf & ~b[CCF_BIT];
                  s_nxt.saf = s_r.saf & ~b[SAF_BIT];
                end
                default: s_nxt.dir = s_r.dir;
              endcase
            end
            // Leaving a multibyte unit early abandons it; this follows the status write so the set wins.
            if (cnt != 2'h0) begin
              s_nxt.saf = 1'b1;
            end
            cnt = 2'h0;
            s_nxt.mb_bad = 1'b0;
          end else begin
            // Multibyte unit: bytes are staged and only the last one commits.
            if (cnt == 2'h0 && k != kstart) begin
              s_nxt.mb_bad = 1'b1;
              s_nxt.saf = 1'b1;
            end
            s_nxt.stage[k*8+:8] = b;
            cnt = 2'(cnt + 2'h1);
            if (cnt == sz) begin
              if (!s_r.rd && !s_r.mb_bad && !s_nxt.mb_bad) begin
                if (is_reg16(s_r.addr)) begin
                  s_nxt.r16 = s_nxt.stage[15:0];
                end else if (sz == SIZE_THREE) begin
                  s_nxt.r24 = s_nxt.stage;
                end
              end
              cnt = 2'h0;
              s_nxt.mb_bad = 1'b0;
            end
          end
          if (s_r.single) begin
            // Each byte needs a fresh instruction in this mode.
            if (cnt != 2'h0) begin
              s_nxt.saf = 1'b1;
            end
            cnt = 2'h0;
            s_nxt.mb_bad = 1'b0;
            s_nxt.phase = SRAF_INSTR;
            s_nxt.sdo_oe = 1'b0;
          end else begin
            s_nxt.addr = a_next;
            s_nxt.tx = read_byte(s_r, a_next);
          end
          s_nxt.mb_cnt = cnt;
        end
      end
    end
    // A low enable holds everything, synchronisers included, so pin edges while it is low go unseen and none is invented.
    if (!ce_i) begin
      s_nxt = s_r;
    end
  end

  // Reset leaves the interface streaming, descending and with short addresses.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
      s_r.sync.cs1 <= 1'b1;
      s_r.sync.cs2 <= 1'b1;
      s_r.phase <= SRAF_IDLE;
      s_r.dir <= DIR_RST;
      s_r.single <= SINGLE_RST;
      s_r.short_ins <= SHORT_RST;
      s_r.r16 <= R16_RST;
      s_r.r24 <= R24_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a field of the state register, so no pin reaches an output combinationally.
  assign sdo_o = s_r.sdo;
  assign sdo_oe_o = s_r.sdo_oe;
  assign reg16_o = s_r.r16;
  assign reg24_o = s_r.r24;
  assign clock_count_fault_o = s_r.ccf;
  assign split_access_fault_o = s_r.saf;

endmodule

// file: verif/sraf_monitor.sv
// Concurrent checks on the ports of the SPI register access front end.
module sraf_monitor (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic [15:0] reg16_o,
  input wire logic [23:0] reg24_o,
  input wire logic clock_count_fault_o,
  input wire logic split_access_fault_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Eight cycles covers the chip-select synchroniser and any commit still in flight.
  sequence s_deselected;
    cs_b_i [*8];
  endsequence
  sequence s_sclk_high;
    sclk_i [*2];
  endsequence
  property p_idle_quiet;
    s_deselected |-> !sdo_oe_o;
  endproperty
  property p_regs_frozen;
    s_deselected |-> $stable(reg16_o) && $stable(reg24_o);
  endproperty
  property p_faults_frozen;
    s_deselected |-> $stable({clock_count_fault_o, split_access_fault_o});
  endproperty
  property p_commit_in_high;
    $changed(reg16_o) || $changed(reg24_o) |-> s_sclk_high;
  endproperty
  property p_sdo_on_low;
    $changed(sdo_o) |-> !sclk_i;
  endproperty
  property p_drive_start;
    $rose(sdo_oe_o) |-> !sclk_i && !cs_b_i;
  endproperty
  property p_count_fault;
    $rose(clock_count_fault_o) |-> $past(cs_b_i);
  endproperty
  property p_fault_clear;
    $fell(clock_count_fault_o) || $fell(split_access_fault_o) |-> !cs_b_i && sclk_i;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output enabled while deselected");
  a_regs_frozen: assert property (p_regs_frozen) else $error("register moved while deselected");
  a_faults_frozen: assert property (p_faults_frozen) else $error("fault moved while deselected");
  a_commit_in_high: assert property (p_commit_in_high) else $error("commit away from clock rise");
  a_sdo_on_low: assert property (p_sdo_on_low) else $error("data out moved while clock high");
  a_drive_start: assert property (p_drive_start) else $error("drive began at wrong moment");
  a_count_fault: assert property (p_count_fault) else $error("count fault outside frame end");
  a_fault_clear: assert property (p_fault_clear) else $error("fault cleared without write");
endmodule

bind sraf_frontend sraf_monitor sraf_monitor_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .cs_b_i(cs_b_i), .sclk_i(sclk_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .reg16_o(reg16_o),
  .reg24_o(reg24_o), .clock_count_fault_o(clock_count_fault_o), .split_access_fault_o(split_access_fault_o));

// file: verif/sraf_host_model.sv
// Behavioural SPI host that frames mode 0 transfers for the front end.
module sraf_host_model (
  output logic cs_b_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic frame(input logic [31:0] v, input int n, output logic [31:0] got);
    got = '0;
    cs_b_o = 1'b0;
    #32;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = v[i];
      #32;
      got = {got[30:0], sdo_i};
      sclk_o = 1'b1;
      #32;
      sclk_o = 1'b0;
    end
    #32;
    cs_b_o = 1'b1;
    // A deselected host gives no valid data, so the line is flipped.
    sdi_o = ~sdi_o;
    #64;
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the SPI register access front end.
module testbench;
  import sraf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] MID = 16'h5a3c; // Arbitrary value.
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic cs_b, sclk, sdi, sdo, sdo_oe, ccf, saf;
  logic [15:0] r16;
  logic [23:0] r24;
  logic [31:0] got;
  logic sdo_line;
  int err_count = 0;
  int checks = 0;
  always #2 core_clk_i = ~core_clk_i;
  sraf_frontend #(.MAKER_ID(MID)) sraf_frontend_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .cs_b_i(cs_b), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .reg16_o(r16), .reg24_o(r24),
    .clock_count_fault_o(ccf), .split_access_fault_o(saf));
  // A released data line shows the inverse, so a read taken outside the drive window fails.
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  sraf_host_model sraf_host_model_inst (.cs_b_o(cs_b), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo_line));
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic xf(input logic [31:0] v, input int n);
    sraf_host_model_inst.frame(v, n, got);
  endtask
  task automatic clr();
    xf({16'h0, 8'h03, 8'h14}, 16);
    chk("faults", 24'({ccf, saf}), 24'h0);
  endtask
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (8) @(posedge core_clk_i);
    #1;
    chk("reg24", r24, 24'h0);
    xf({16'h0, 8'h82, 8'h00}, 16);
    chk("enforce", 24'(got[5]), 24'h1);
    xf({16'h0, 8'h02, 8'h00}, 16);
    xf({16'h0, 8'h82, 8'h00}, 16);
    chk("enforce ro", 24'(got[5]), 24'h1);
    xf({8'h0, 8'h8d, 16'h0}, 24);
    chk("maker", 24'(got[15:0]), 24'(MID));
    chk("whole read", 24'(saf), 24'h0);
    xf({8'h0, 8'h11, 16'haa55}, 24);
    chk("reg16", 24'(r16), 24'h00aa55);
    xf({16'h0, 8'h11, 8'h12}, 16);
    chk("reg16 split", 24'(r16), 24'h00aa55);
    chk("split", 24'(saf), 24'h1);
    clr();
    xf({20'h0, 8'h10, 4'h5}, 12);
    chk("reg16 part", 24'(r16), 24'h00aa55);
    chk("count", 24'(ccf), 24'h1);
    clr();
    xf({16'h0, 8'h8d, 8'h00}, 16);
    chk("byte read", 24'(got[7:0]), 24'(MID[15:8]));
    chk("byte split", 24'(saf), 24'h1);
    clr();
    xf({28'h0, 4'h8}, 4);
    chk("cut instr", 24'({ccf, saf}), 24'h0);
    xf({16'h0, 8'h00, 8'h20}, 16);
    xf({8'h12, 24'h332211}, 32);
    chk("reg24 asc", r24, 24'h112233);
    xf({16'h0, 8'h01, 8'h00}, 16);
    xf({16'h0010, 16'hbeef}, 32);
    chk("long addr", 24'(r16), 24'h00efbe);
    xf({8'h0, 16'h0001, 8'h88}, 24);
    xf({8'h10, 8'h01, 8'h11, 8'h02}, 32);
    chk("single", 24'(r16), 24'h00efbe);
    chk("single split", 24'(saf), 24'h1);
    xf({8'h82, 8'h00, 8'h8c, 8'h00}, 32);
    chk("two instr", 24'({got[21], got[7:0]}), 24'({1'b1, MID[7:0]}));
    // With the clock enable low the whole frame is unseen, so the clear write is lost.
    ce_i = 1'b0;
    xf({16'h0, 8'h03, 8'h14}, 16);
    ce_i = 1'b1;
    chk("frozen", 24'(saf), 24'h1);
    clr();
    report_and_stop();
  end
endmodule
